// *** pkg/amct_pkg.sv ***
// Package of constants and types for converter mode and timing control
package amct_pkg;
    // Register offsets (byte addresses on the register port) and reset values
    localparam logic [7:0] CONV_TIME_BASE = 8'h30;
    localparam logic [7:0] MODE_BASE      = 8'h38;
    localparam logic [7:0] CONV_TIME_RST  = 8'h91;
    localparam logic [7:0] MODE_RST       = 8'h00;
    // Field positions
    localparam int POLARITY_SWAP_ENABLE_BIT   = 7;
    localparam int MODE_HI    = 7;
    localparam int MODE_LO    = 5;
    localparam int CLOCK_OUTPUT_DISABLE_BIT = 4;
    localparam int DUMP_BIT   = 3;
    localparam int CONTRD_BIT = 2;
    localparam int WIDE_BIT   = 1;
    localparam int CLAMP_BIT  = 0;
    // Conversion time coefficients in master-clock cycles and minimum filter words
    localparam logic [15:0] POLARITY_SWAP_ENABLE_MUL    = 16'h0080;
    localparam logic [15:0] POLARITY_SWAP_ENABLE_ADD1   = 16'h00f8;
    localparam logic [15:0] POLARITY_SWAP_ENABLE_ADDN   = 16'h00f9;
    localparam logic [15:0] NOCHOP_MUL  = 16'h0040;
    localparam logic [15:0] NOCHOP_ADD1 = 16'h00ce;
    localparam logic [15:0] NOCHOP_ADDN = 16'h00cf;
    localparam logic [6:0]  POLARITY_SWAP_ENABLE_FW_MIN   = 7'h02;
    localparam logic [6:0]  NOCHOP_FW_MIN = 7'h03;
    // Mode codes
    typedef enum logic [2:0] {
        MODE_IDLE   = 3'h0,
        MODE_CONT   = 3'h1,
        MODE_SINGLE = 3'h2,
        MODE_STBY   = 3'h3,
        MODE_SELFZ  = 3'h4,
        MODE_RSVD   = 3'h5,
        MODE_SYSZ   = 3'h6,
        MODE_SYSF   = 3'h7
    } amct_mode_t;
    // Sequencer states, Gray along idle, run, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } amct_state_t;
endpackage

// *** design/amct_conv_timer.sv ***
// Conversion period counter driven by the master clock
`timescale 1ns/10ps
module amct_conv_timer
    import amct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        clkRun,
    input  wire logic [7:0]  convTime,
    input  wire logic        multiChan,
    output logic             busy,
    output logic             done
);
    logic [15:0] cyclesD;
    logic [15:0] countQ;
    logic [15:0] fwWide;

    // Period from filter word and chopping setting
    always_comb begin
        fwWide = {9'h000, convTime[6:0]};
        if (convTime[POLARITY_SWAP_ENABLE_BIT]) begin
            cyclesD = 16'(fwWide * POLARITY_SWAP_ENABLE_MUL)
                    + (multiChan ? POLARITY_SWAP_ENABLE_ADDN : POLARITY_SWAP_ENABLE_ADD1);
        end else begin
            cyclesD = 16'(fwWide * NOCHOP_MUL)
                    + (multiChan ? NOCHOP_ADDN : NOCHOP_ADD1);
        end
    end

    // Down counter; one cycle per master clock edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            countQ <= 16'h0000;
        end else if (abort) begin
            countQ <= 16'h0000;
        end else if (start) begin
            countQ <= cyclesD;
        end else if (countQ != 16'h0000 && clkRun) begin
            countQ <= countQ - 16'h0001;
        end
    end

    assign busy = (countQ != 16'h0000);
    assign done = clkRun && !abort && !start && (countQ == 16'h0001);

    a_timer_load: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        start && !abort |=> countQ == $past(cyclesD)
    ) else $error("timer not loaded with period");
endmodule // amct_conv_timer

// *** design/amct_mode_ctrl.sv ***
// Mode register, conversion time registers and conversion sequencer
`timescale 1ns/10ps
module amct_mode_ctrl
    import amct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    input  wire logic [3:0]  chanEnable,
    input  wire logic        crystalMode,
    input  wire logic        rawOverRange,
    input  wire logic        rawNegative,
    input  wire logic [23:0] rawResult,
    output logic             masterClockOutEn,
    output logic             masterClockOut,
    output logic             readyPin_n,
    output logic      [3:0]  chanReady,
    output logic             statusClear,
    output logic             resultValid,
    output logic      [1:0]  resultChan,
    output logic      [23:0] resultData,
    output logic             resultWide,
    output logic             dumpRead,
    output logic             contRead,
    output logic      [1:0]  calibKind,
    output logic             calibDone,
    output logic             standby,
    output logic             convActive,
    output logic      [1:0]  activeChan
);
    logic [7:0]  convTimeQ [4];
    logic [7:0]  modeQ;
    logic [1:0]  chanQ;
    logic [1:0]  chanD;
    amct_state_t stateQ;
    logic        modeWrite;
    logic        convTimeWrite;
    logic        startQ;
    logic        tmrBusy;
    logic        tmrDone;
    logic        clkRun;
    logic        multiChan;
    logic        readyPinQ;
    logic [3:0]  chanReadyQ;
    logic        clkToggleQ;
    amct_mode_t  curMode;
    logic [2:0]  enCount;
    logic [1:0]  timeChan;

    // Address decode; mode answers at 38h to 3Bh
    assign modeWrite     = regWrite && (regAddr[7:2] == MODE_BASE[7:2]);
    assign convTimeWrite = regWrite && (regAddr[7:2] == CONV_TIME_BASE[7:2]);
    assign curMode       = amct_mode_t'(modeQ[MODE_HI:MODE_LO]);

    // Conversion time registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                convTimeQ[i] <= CONV_TIME_RST;
            end
        end else if (convTimeWrite) begin
            convTimeQ[regAddr[1:0]] <= regWdata;
        end
    end

    // Mode register; hardware clears mode bits at end of one-shot modes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeQ <= MODE_RST;
            chanQ <= 2'h0;
        end else if (modeWrite) begin
            modeQ <= regWdata;
            chanQ <= regAddr[1:0];
        end else if (stateQ == ST_DONE && curMode != MODE_CONT) begin
            modeQ[MODE_HI:MODE_LO] <= MODE_IDLE;
        end else if (stateQ == ST_DONE) begin
            chanQ <= chanD;
        end
    end

    // Read mux; mode is read only at its base address
    always_comb begin
        regRdata = 8'h00;
        if (regRead && regAddr == MODE_BASE) begin
            regRdata = modeQ;
        end else if (regRead && regAddr[7:2] == CONV_TIME_BASE[7:2]) begin
            regRdata = convTimeQ[regAddr[1:0]];
        end
    end

    // Next enabled channel after the current one, wrapping
    always_comb begin
        chanD = chanQ;
        for (int k = 3; k >= 1; k--) begin
            if (chanEnable[2'(chanQ + 2'(k))]) begin
                chanD = 2'(chanQ + 2'(k));
            end
        end
    end

    // Enabled channel count selects the several-channel timing
    always_comb begin
        enCount = 3'h0;
        for (int j = 0; j < 4; j++) begin
            enCount = enCount + {2'h0, chanEnable[j]};
        end
    end
    assign multiChan = (curMode == MODE_CONT) && (enCount > 3'h1);

    // Reload on a channel step uses the next channel's time register
    assign timeChan = (stateQ == ST_DONE) ? chanD : chanQ;

    // Crystal with output disabled freezes conversions
    assign clkRun = !(crystalMode && modeQ[CLOCK_OUTPUT_DISABLE_BIT]);

    // Sequencer; a mode write aborts and restarts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ST_IDLE;
            startQ <= 1'b0;
        end else if (modeWrite) begin
            stateQ <= ST_IDLE;
            startQ <= 1'b1;
        end else begin
            startQ <= 1'b0;
            unique case (stateQ)
                ST_IDLE: begin
                    if (startQ && curMode != MODE_IDLE && curMode != MODE_STBY
                        && curMode != MODE_RSVD) begin
                        stateQ <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tmrDone) begin
                        stateQ <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (curMode == MODE_CONT && chanEnable != 4'h0) begin
                        stateQ <= ST_RUN;
                    end else begin
                        stateQ <= ST_IDLE;
                    end
                end
                default: stateQ <= ST_IDLE;
            endcase
        end
    end

    amct_conv_timer u_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .start     ((stateQ == ST_IDLE && startQ) || stateQ == ST_DONE),
        .abort     (modeWrite),
        .clkRun    (clkRun),
        .convTime  (convTimeQ[timeChan]),
        .multiChan (multiChan),
        .busy      (tmrBusy),
        .done      (tmrDone)
    );

    // Result capture with clamp and width handling
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resultValid <= 1'b0;
            resultChan  <= 2'h0;
            resultData  <= 24'h000000;
            calibDone   <= 1'b0;
        end else begin
            resultValid <= 1'b0;
            calibDone   <= 1'b0;
            if (stateQ == ST_RUN && tmrDone && !modeWrite) begin
                if (curMode == MODE_CONT || curMode == MODE_SINGLE) begin
                    resultValid <= 1'b1;
                    resultChan  <= chanQ;
                    if (modeQ[CLAMP_BIT] && rawOverRange) begin
                        resultData <= rawNegative ? 24'h000000
                                                  : 24'hffffff;
                    end else if (modeQ[WIDE_BIT]) begin
                        resultData <= rawResult;
                    end else begin
                        resultData <= {8'h00, rawResult[23:8]};
                    end
                end else begin
                    calibDone <= 1'b1;
                end
            end
        end
    end

    // Ready flags and pin; a mode write clears, conversion completion sets
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chanReadyQ <= 4'h0;
            readyPinQ  <= 1'b1;
        end else if (modeWrite) begin
            chanReadyQ <= 4'h0;
            readyPinQ  <= 1'b1;
        end else if (stateQ == ST_RUN && tmrDone
                     && (curMode == MODE_CONT || curMode == MODE_SINGLE)) begin
            chanReadyQ[chanQ] <= 1'b1;
            readyPinQ  <= 1'b0;
        end
    end

    // Master clock output divided from core clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkToggleQ <= 1'b0;
        end else begin
            clkToggleQ <= ~clkToggleQ;
        end
    end

    // Output assignments
    assign masterClockOutEn = !modeQ[CLOCK_OUTPUT_DISABLE_BIT];
    assign masterClockOut   = clkToggleQ;
    assign readyPin_n       = readyPinQ;
    assign chanReady        = chanReadyQ;
    assign statusClear      = modeWrite;
    assign resultWide       = modeQ[WIDE_BIT];
    assign dumpRead         = modeQ[DUMP_BIT] || modeQ[CONTRD_BIT];
    assign contRead         = modeQ[CONTRD_BIT];
    assign calibKind        = modeQ[6:5];
    assign standby          = (curMode == MODE_STBY);
    assign convActive       = tmrBusy;
    assign activeChan       = chanQ;

    a_write_clears_ready: assert property (@(posedge core_clk)
        disable iff (!rst_n) modeWrite |=> readyPin_n && chanReady == 4'h0
    ) else $error("mode write did not clear ready");
    a_single_to_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_DONE && curMode == MODE_SINGLE && !modeWrite
        |=> curMode == MODE_IDLE
    ) else $error("single conversion did not return to idle");
    a_reset_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> modeQ == MODE_RST
    ) else $error("mode not reset");
    a_clkout_disable: assert property (@(posedge core_clk)
        disable iff (!rst_n) modeQ[CLOCK_OUTPUT_DISABLE_BIT] |-> !masterClockOutEn
    ) else $error("clock output not disabled");
    a_mode_write_take: assert property (@(posedge core_clk)
        disable iff (!rst_n) modeWrite |=> modeQ == $past(regWdata)
            && chanQ == $past(regAddr[1:0])
    ) else $error("mode write not taken");
    a_clamp_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_RUN && tmrDone && !modeWrite && curMode == MODE_SINGLE
        && modeQ[CLAMP_BIT] && rawOverRange && !rawNegative
        |=> resultData == 24'hffffff
    ) else $error("clamp failed");
    a_cont_read_dump: assert property (@(posedge core_clk)
        disable iff (!rst_n) contRead |-> dumpRead
    ) else $error("continuous read without dump");
    a_narrow_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        resultValid && !resultWide && !rawOverRange |-> resultData[23:16] == 8'h00
    ) else $error("narrow data has high bits");

    // Checks on abort, completion and channel stepping
    a_status_pulse: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        modeWrite |-> statusClear
    ) else $error("status clear missing on mode write");

    a_abort_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        modeWrite |=> stateQ == ST_IDLE && !convActive
    ) else $error("mode write did not abort conversion");

    a_ready_pin_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_RUN && tmrDone && curMode == MODE_SINGLE && !modeWrite
        |=> !readyPin_n && chanReady[$past(chanQ)]
    ) else $error("single end did not signal ready");

    a_cont_stays: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_DONE && curMode == MODE_CONT && chanEnable != 4'h0
        && !modeWrite |=> stateQ == ST_RUN && curMode == MODE_CONT
    ) else $error("continuous mode did not go on");

    a_next_channel: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_DONE && curMode == MODE_CONT && !modeWrite
        |=> activeChan == $past(chanD)
    ) else $error("continuous mode did not step channel");

    a_calib_to_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_DONE && !modeWrite && (curMode == MODE_SELFZ
        || curMode == MODE_SYSZ || curMode == MODE_SYSF)
        |=> curMode == MODE_IDLE
    ) else $error("calibration did not return to idle");

    a_crystal_freeze: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !clkRun |-> !tmrDone
    ) else $error("conversion ended with clock stopped");

    a_no_start_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stateQ == ST_IDLE && startQ && !modeWrite && (curMode == MODE_IDLE
        || curMode == MODE_STBY || curMode == MODE_RSVD)
        |=> stateQ == ST_IDLE
    ) else $error("idle or standby started a conversion");
endmodule // amct_mode_ctrl

// *** test/amct_host_model.sv ***
// Host model driving the register port of the mode and timing block
`timescale 1ns/10ps
module amct_host_model (
    input  wire logic       core_clk,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    // Quiet bus at time zero
    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // One write; reserved mode code never sent
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (a[7:2] == 6'h0e && d[7:5] == 3'h5) return;
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regWdata <= ~d;  // Released data shows inverse
    endtask

    // Read held over one edge; mode read only at its base
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        d = regRdata;
        regRead <= 1'b0;
    endtask
endmodule // amct_host_model

// *** test/tb_adc_mode_and_conversion_timing.sv ***
// Self-checking bench for converter mode and conversion timing control
`timescale 1ns/10ps
module tb_adc_mode_and_conversion_timing
    import amct_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWrite, regRead, masterClockOutEn, readyPin_n;
    logic [7:0]  regAddr, regWdata, regRdata, rd;
    logic [3:0]  chanEnable = 4'h0;
    logic        crystalMode = 1'b0;
    logic        rawOverRange = 1'b0;
    logic        rawNegative = 1'b0;
    logic [23:0] rawResult = 24'h123456;
    logic        resultValid, resultWide, dumpRead, contRead;
    logic        calibDone, standby, convActive;
    logic [3:0]  chanReady;
    logic [1:0]  resultChan, calibKind;
    logic [23:0] resultData;
    logic [7:0]  tv [4] = '{8'h82, 8'h83, 8'h03, 8'h04};
    logic [7:0]  dm [4] = '{8'h40, 8'h43, 8'h43, 8'h42};
    logic [23:0] de [4] = '{24'h001234, 24'h0, 24'hffffff, 24'h123456};
    logic [7:0]  cm [3] = '{8'h80, 8'hc0, 8'he0};
    int          errors = 0;
    int          comparisons = 0;
    int          t [4];
    int          c, p1, p2;
    logic        mco, m1, statusClear;
    logic [1:0]  activeChan;
    int          clears = 0;
    int          clr0;

    // Master clock
    always #25 core_clk = ~core_clk;

    amct_host_model host (.core_clk(core_clk), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata));

    amct_mode_ctrl dut (.core_clk(core_clk), .rst_n(rst_n),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .chanEnable(chanEnable),
        .crystalMode(crystalMode), .rawOverRange(rawOverRange),
        .rawNegative(rawNegative), .rawResult(rawResult),
        .masterClockOutEn(masterClockOutEn), .masterClockOut(mco),
        .readyPin_n(readyPin_n), .chanReady(chanReady),
        .statusClear(statusClear),
        .resultValid(resultValid), .resultChan(resultChan),
        .resultData(resultData), .resultWide(resultWide),
        .dumpRead(dumpRead), .contRead(contRead), .calibKind(calibKind),
        .calibDone(calibDone), .standby(standby), .convActive(convActive),
        .activeChan(activeChan));

    // Count status clear pulses
    always @(posedge core_clk) begin
        if (statusClear === 1'b1) begin
            clears <= clears + 1;
        end
    end

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        chk_val(24'(got), 24'(exp));
    endtask

    // Cycles until the next result pulse, capped
    task automatic wait_valid(input int lim, output int cyc);
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
        end while (resultValid !== 1'b1 && cyc < lim);
    endtask

    task automatic single(input int ch, input logic [7:0] md, output int n);
        host.write_reg(MODE_BASE + 8'(ch), md);
        wait_valid(20000, n);
    endtask

    task automatic tally_and_finish;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            host.read_reg(CONV_TIME_BASE + 8'(i), rd);
            chk_val(rd, 24'h91);
        end
        host.read_reg(MODE_BASE, rd);
        chk_val(rd, 24'h00);
        host.read_reg(8'h3c, rd);
        chk_val(rd, 24'h00);
        chk_val({readyPin_n, masterClockOutEn}, 24'h3);
        @(negedge core_clk);
        m1 = mco;
        @(negedge core_clk);
        chk_val({23'h0, mco}, {23'h0, ~m1});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            host.write_reg(CONV_TIME_BASE + 8'(i), tv[i]);
            host.read_reg(CONV_TIME_BASE + 8'(i), rd);
            chk_val(rd, tv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            single(i, 8'h42, t[i]);
            chk_val(resultChan, 24'(i));
            chk_val({22'h0, activeChan}, 24'(i));
            chk_val(resultData, rawResult);
            repeat (3) @(negedge core_clk);
            chk_val({readyPin_n, chanReady}, {20'h0, 4'h1 << i});
            host.read_reg(MODE_BASE, rd);
            chk_val(rd, 24'h02);
        end
        chk_cnt(t[1] - t[0], 128);
        chk_cnt(t[0] - t[2], (2 * 128 + 248) - (3 * 64 + 206));
        chk_cnt(t[3] - t[2], 64);
        $display("test single done");
        for (int j = 0; j < 4; j++) begin
            @(posedge core_clk);
            rawOverRange <= (j != 0);
            rawNegative <= (j != 2);
            single(0, dm[j], c);
            chk_val(resultData, de[j]);
        end
        clr0 = clears;
        host.write_reg(MODE_BASE, 8'h00);
        repeat (2) @(negedge core_clk);
        chk_val({readyPin_n, chanReady}, 24'h10);
        chk_cnt(clears - clr0, 1);
        host.write_reg(CONV_TIME_BASE, 8'hff);
        host.write_reg(MODE_BASE, 8'h40);
        repeat (50) @(negedge core_clk);
        chk_val(convActive, 24'h1);
        single(1, 8'h42, c);
        chk_cnt(c, t[1]);
        $display("test data and abort done");
        @(posedge core_clk);
        chanEnable <= 4'b0010;
        host.write_reg(MODE_BASE + 8'h01, 8'h20);
        wait_valid(20000, c);
        wait_valid(20000, p1);
        @(posedge core_clk);
        chanEnable <= 4'b0100;
        host.write_reg(MODE_BASE + 8'h02, 8'h20);
        wait_valid(20000, c);
        wait_valid(20000, p2);
        @(posedge core_clk);
        chanEnable <= 4'b0110;
        host.write_reg(MODE_BASE + 8'h01, 8'h20);
        wait_valid(20000, c);
        wait_valid(20000, c);
        chk_val(resultChan, 24'h2);
        chk_cnt(c - p2, 1);
        wait_valid(20000, c);
        chk_val(resultChan, 24'h1);
        chk_cnt(c - p1, 1);
        host.read_reg(MODE_BASE, rd);
        chk_val(rd, 24'h20);
        $display("test continuous done");
        host.write_reg(MODE_BASE, 8'h10);
        @(negedge core_clk);
        chk_val(masterClockOutEn, 24'h0);
        single(1, 8'h52, c);
        chk_cnt(c, t[1]);
        @(posedge core_clk);
        crystalMode <= 1'b1;
        host.write_reg(MODE_BASE + 8'h01, 8'h52);
        wait_valid(1000, c);
        chk_cnt(c, 1000);
        host.read_reg(CONV_TIME_BASE + 8'h01, rd);
        chk_val(rd, 24'h83);
        @(posedge core_clk);
        crystalMode <= 1'b0;
        host.write_reg(MODE_BASE, 8'h6e);
        @(negedge core_clk);
        chk_val({standby, dumpRead, contRead, resultWide, convActive},
            24'h1e);
        host.write_reg(MODE_BASE, 8'h00);
        @(negedge core_clk);
        chk_val({standby, dumpRead, contRead, resultWide}, 24'h0);
        $display("test options done");
        for (int k = 0; k < 3; k++) begin
            host.write_reg(MODE_BASE + 8'h01, cm[k]);
            @(negedge core_clk);
            chk_val(calibKind, 24'(cm[k][6:5]));
            c = 0;
            while (calibDone !== 1'b1 && c < 20000) begin
                @(negedge core_clk);
                c++;
            end
            chk_val(calibDone, 24'h1);
            repeat (3) @(negedge core_clk);
            host.read_reg(MODE_BASE, rd);
            chk_val(rd, 24'h00);
        end
        $display("test calibration done");
        tally_and_finish();
    end
endmodule // tb_adc_mode_and_conversion_timing
